// [pbm_pkg.sv]
package pbm_pkg;

   // ****************************************
   // Direct register indexes
   // ****************************************
   localparam logic [4:0] REG_CTRL    = 5'h00;   // Basic control
   localparam logic [4:0] REG_STAT    = 5'h01;   // Basic status
   localparam logic [4:0] REG_MMD_CTL = 5'h0D;   // Indirect access control
   localparam logic [4:0] REG_MMD_DAT = 5'h0E;   // Indirect address / data
   localparam logic [4:0] REG_FUNC    = 5'h1C;   // Function control

   // ****************************************
   // Basic control bit positions
   // ****************************************
   localparam int B_RST  = 15;   // Software reset, self clearing
   localparam int B_LPBK = 14;   // Loopback
   localparam int B_SPD  = 13;   // Speed select
   localparam int B_ANEN = 12;   // Negotiation enable
   localparam int B_PD   = 11;   // Power down
   localparam int B_ISO  = 10;   // Isolate
   localparam int B_ANRS = 9;    // Restart negotiation, self clearing
   localparam int B_DPX  = 8;    // Duplex mode
   localparam int B_COLT = 7;    // Collision test

   // ****************************************
   // Reset values and write masks
   // ****************************************
   localparam logic [15:0] CTRL_RST_VAL  = 16'h0000;   // Straps fill in afterwards
   localparam logic [15:0] CTRL_WR_MASK  = 16'h7D80;   // Stored writable bits
   localparam logic [15:0] STAT_VAL      = 16'h7849;   // Fixed capability bits
   localparam int          STAT_B_ANC    = 5;          // Negotiation complete
   localparam int          STAT_B_LINK   = 2;          // Link status
   localparam logic [15:0] FUNC_RST_VAL  = 16'h0000;   // Function control reset
   localparam logic [15:0] FUNC_WR_MASK  = 16'h0002;   // Only loopback enable stored
   localparam int          FUNC_B_LPBK   = 1;          // Loopback enable in 1Ch

   // ****************************************
   // Indirect register space
   // ****************************************
   localparam logic [4:0]  DEV_RSV    = 5'h07;      // Reserved device
   localparam logic [4:0]  DEV_AFE    = 5'h1B;      // Front end device
   localparam logic [4:0]  DEV_SQI    = 5'h1C;      // Signal quality device
   localparam logic [15:0] MMD_A_AFE  = 16'h0000;   // Front-end control
   localparam logic [15:0] MMD_A_SQI  = 16'h00AC;   // Signal quality
   localparam logic [1:0]  MMD_FN_ADR = 2'h0;       // Function field: address
   localparam logic [1:0]  SEL_NONE   = 2'h0;       // No indirect register
   localparam logic [1:0]  SEL_AFE    = 2'h1;       // Front-end control hit
   localparam logic [1:0]  SEL_SQI    = 2'h2;       // Signal quality hit

   // ****************************************
   // Serial frame layout
   // ****************************************
   localparam logic [4:0] FR_HDR_CNT = 5'h0D;   // Header bits after the first
   localparam logic [4:0] FR_WR_CNT  = 5'h12;   // Turnaround plus data bits
   localparam logic [4:0] FR_RD_CNT  = 5'h10;   // Data bits driven on a read
   localparam logic [1:0] FR_ST      = 2'h1;    // Start pattern
   localparam logic [1:0] FR_OP_RD   = 2'h2;    // Read opcode
   localparam logic [1:0] FR_OP_WR   = 2'h1;    // Write opcode

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [4:0] {
      E_IDLE = 5'b00001,
      E_HDR  = 5'b00010,
      E_TA   = 5'b00100,
      E_RDAT = 5'b01000,
      E_WDAT = 5'b10000
   } pbm_eng_st_t;

   typedef struct packed {
      logic        wr;      // Write strobe
      logic        rd;      // Read strobe
      logic [4:0]  addr;    // Register index
      logic [15:0] wdata;   // Write data
   } pbm_req_t;

   typedef struct packed {
      pbm_eng_st_t st;
      logic        mdc_q;
      logic        prev1;
      logic        skip;
      logic [4:0]  cnt;
      logic [15:0] sh;
      pbm_req_t    req;
      logic        mdio_o;
      logic        mdio_oe;
   } pbm_eng_t;

   typedef struct packed {
      logic [15:0] ctl;
      logic [15:0] addr;
      logic [15:0] afe;
      logic [15:0] sqi;
   } pbm_mmd_t;

   typedef struct packed {
      logic        ld;
      logic [15:0] bcr;
      logic [15:0] func;
      logic [15:0] rdata;
      logic        lpbk;
      logic        spd;
      logic        dpx;
      logic        an;
      logic        pd;
      logic        iso;
      logic        anrs;
      logic        colt;
      logic        srst;
   } pbm_main_t;

endpackage

// [pbm_mdio_slave.sv]
`timescale 1ns/1ps
module pbm_mdio_slave #(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              ce,
   input  wire logic              mdc,
   input  wire logic              mdio_i,
   input  wire logic [15:0]       rdata,
   output pbm_pkg::pbm_req_t      req,
   output logic                   mdio_o,
   output logic                   mdio_oe
);

   // ****************************************
   // State
   // ****************************************
   pbm_pkg::pbm_eng_t q;       // Registered state
   pbm_pkg::pbm_eng_t n;       // Next state
   logic [15:0]       hv;      // Shift value with new bit
   logic              rise;    // Sampled clock rising
   logic              hit;     // Frame for this address

   assign req     = q.req;
   assign mdio_o  = q.mdio_o;
   assign mdio_oe = q.mdio_oe;

   // Frame sequencer, sampling on management clock rise
   always_comb begin
      n        = q;
      n.req.wr = 1'b0;
      n.req.rd = 1'b0;
      n.mdc_q  = mdc;
      hv       = {q.sh[14:0], mdio_i};
      rise     = mdc && !q.mdc_q;
      hit      = (hv[13:12] == pbm_pkg::FR_ST) && (hv[9:5] == PHY_ADDR);
      if (rise) begin
         case (q.st)
            // Wait for start after idle ones
            pbm_pkg::E_IDLE: begin
               n.prev1 = mdio_i;
               if (q.prev1 && !mdio_i) begin
                  n.st  = pbm_pkg::E_HDR;
                  n.sh  = hv;
                  n.cnt = pbm_pkg::FR_HDR_CNT;
               end
            end
            // Opcode, address and register fields
            pbm_pkg::E_HDR: begin
               n.sh  = hv;
               n.cnt = q.cnt - 5'd1;
               if (q.cnt == 5'd1) begin
                  n.req.addr = hv[4:0];
                  if (hit && hv[11:10] == pbm_pkg::FR_OP_RD) begin
                     n.req.rd = 1'b1;
                     n.st     = pbm_pkg::E_TA;
                  end else begin
                     n.skip = !(hit && hv[11:10] == pbm_pkg::FR_OP_WR);
                     n.st   = pbm_pkg::E_WDAT;
                     n.cnt  = pbm_pkg::FR_WR_CNT;
                  end
               end
            end
            // Second turnaround bit driven low
            pbm_pkg::E_TA: begin
               n.mdio_oe = 1'b1;
               n.mdio_o  = 1'b0;
               n.sh      = rdata;
               n.cnt     = pbm_pkg::FR_RD_CNT;
               n.st      = pbm_pkg::E_RDAT;
            end
            // Read data out, most significant first
            pbm_pkg::E_RDAT: begin
               if (q.cnt == 5'd0) begin
                  n.mdio_oe = 1'b0;
                  n.prev1   = 1'b0;
                  n.st      = pbm_pkg::E_IDLE;
               end else begin
                  n.mdio_o = q.sh[15];
                  n.sh     = {q.sh[14:0], 1'b0};
                  n.cnt    = q.cnt - 5'd1;
               end
            end
            // Write data in, or skip a foreign frame
            pbm_pkg::E_WDAT: begin
               n.sh  = hv;
               n.cnt = q.cnt - 5'd1;
               if (q.cnt == 5'd1) begin
                  n.req.wr    = !q.skip;
                  n.req.wdata = hv;
                  n.prev1     = 1'b0;
                  n.st        = pbm_pkg::E_IDLE;
               end
            end
            default: begin
               n.st = pbm_pkg::E_IDLE;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q    <= '0;
         q.st <= pbm_pkg::E_IDLE;
      end else if (ce) begin
         q <= n;
      end
   end

endmodule

// [pbm_mmd_regs.sv]
`timescale 1ns/1ps
module pbm_mmd_regs (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              ce,
   input  wire logic              srst,
   input  wire pbm_pkg::pbm_req_t req,
   output logic [15:0]            ctl_o,
   output logic [15:0]            dat_o
);

   // ****************************************
   // State
   // ****************************************
   pbm_pkg::pbm_mmd_t q;      // Registered state
   pbm_pkg::pbm_mmd_t n;      // Next state
   logic              dmode;  // Data function selected

   // Indirect register decode
   function automatic logic [1:0] mmd_sel(input logic [4:0] dev, input logic [15:0] a);
      if (dev == pbm_pkg::DEV_AFE && a == pbm_pkg::MMD_A_AFE) begin
         mmd_sel = pbm_pkg::SEL_AFE;   // R2
      end else if (dev == pbm_pkg::DEV_SQI && a == pbm_pkg::MMD_A_SQI) begin
         mmd_sel = pbm_pkg::SEL_SQI;   // R2
      end else begin
         mmd_sel = pbm_pkg::SEL_NONE;  // R2
      end
   endfunction

   assign dmode = q.ctl[15:14] != pbm_pkg::MMD_FN_ADR;
   assign ctl_o = q.ctl;

   // Read data for the address/data register
   always_comb begin
      if (!dmode) begin
         dat_o = q.addr;
      end else begin
         case (mmd_sel(q.ctl[4:0], q.addr))
            pbm_pkg::SEL_AFE: dat_o = q.afe;
            pbm_pkg::SEL_SQI: dat_o = q.sqi;
            default:          dat_o = 16'h0000;
         endcase
      end
   end

   // Indirect access through control and data registers
   always_comb begin
      n = q;
      if (srst) begin
         n = '0;
      end else if (req.wr && req.addr == pbm_pkg::REG_MMD_CTL) begin
         n.ctl = req.wdata;                                          // R3
      end else if (req.wr && req.addr == pbm_pkg::REG_MMD_DAT) begin
         if (!dmode) begin
            n.addr = req.wdata;                                      // R3
         end else begin
            case (mmd_sel(q.ctl[4:0], q.addr))
               pbm_pkg::SEL_AFE: n.afe = req.wdata;
               pbm_pkg::SEL_SQI: n.sqi = req.wdata;
               default:          n.afe = q.afe;                      // R2
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else if (ce) begin
         q <= n;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst || !ce);

   sequence s_dat_wr;
      req.wr && req.addr == pbm_pkg::REG_MMD_DAT && dmode && !srst;
   endsequence

   mmd_rsv_keep_a: assert property (  // R2
      s_dat_wr ##0 (q.ctl[4:0] == pbm_pkg::DEV_RSV) |=> $stable(q.afe) && $stable(q.sqi))
      else $error("reserved indirect write changed storage");

   mmd_afe_store_a: assert property (  // R3
      s_dat_wr ##0 (mmd_sel(q.ctl[4:0], q.addr) == pbm_pkg::SEL_AFE)
      |=> q.afe == $past(req.wdata) ##1 dat_o == $past(req.wdata, 2))
      else $error("front-end indirect write not stored");

endmodule

// [pbm_mgmt_regs.sv]
`timescale 1ns/1ps
// Contract
// (R1) 32 direct registers, unused vendor ones read zero
// (R2) Decode front-end and signal quality indirect registers
// (R3) Indirect registers reached through Dh and Eh
// (R4) Bit 15 starts soft reset, reads zero
// (R5) Loopback needs bit 14 and function enable
// (R6) Bit 13 selects 100/10, ignored under negotiation
// (R7) Speed reset value from strap or one
// (R8) Bit 12 from strap; negotiation overrides speed/duplex
// (R9) Power down; first reset write only wakes
// (R10) Bit 10 isolates the media interface
// (R11) Bit 9 restarts negotiation, self clears
// (R12) Duplex resets to inverse of duplex strap; small package resets it to one
// (R13) Collision test bit 7; bits 6:0 zero
// (R14) Status reports T4 absent, 100 capable
// (R15) Read-only and reserved bits ignore writes
module pbm_mgmt_regs #(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic ce,
   input  wire logic mdc,
   input  wire logic mdio_i,
   output logic      mdio_o,
   output logic      mdio_oe,
   input  wire logic pkg_large,
   input  wire logic strap_speed,
   input  wire logic strap_duplex,
   input  wire logic negotiation_strap_pin,
   input  wire logic an_res_speed,
   input  wire logic an_res_duplex,
   input  wire logic an_done,
   input  wire logic link_up,
   output logic      loopback_on,
   output logic      speed_100,
   output logic      full_duplex,
   output logic      an_enable,
   output logic      power_down,
   output logic      isolate,
   output logic      an_restart,
   output logic      col_test,
   output logic      soft_reset
);

   // ****************************************
   // Declarations
   // ****************************************
   pbm_pkg::pbm_main_t q;         // Registered state
   pbm_pkg::pbm_main_t n;         // Next state
   pbm_pkg::pbm_req_t  req;       // Decoded frame request
   logic [15:0]        mmd_ctl;   // Indirect control readback
   logic [15:0]        mmd_dat;   // Indirect data readback
   logic [15:0]        stat_v;    // Live status word
   logic [15:0]        wd;        // Write data shorthand

   // ****************************************
   // Serial frame engine
   // ****************************************
   pbm_mdio_slave #(
      .PHY_ADDR (PHY_ADDR)
   ) u_eng (
      .clk     (clk),
      .nrst    (nrst),
      .ce      (ce),
      .mdc     (mdc),
      .mdio_i  (mdio_i),
      .rdata   (q.rdata),
      .req     (req),
      .mdio_o  (mdio_o),
      .mdio_oe (mdio_oe)
   );

   // ****************************************
   // Indirect register space
   // ****************************************
   pbm_mmd_regs u_mmd (
      .clk   (clk),
      .nrst  (nrst),
      .ce    (ce),
      .srst  (q.srst),
      .req   (req),
      .ctl_o (mmd_ctl),
      .dat_o (mmd_dat)
   );

   // Outputs straight from state flops
   assign loopback_on = q.lpbk;
   assign speed_100   = q.spd;
   assign full_duplex = q.dpx;
   assign an_enable   = q.an;
   assign power_down  = q.pd;
   assign isolate     = q.iso;
   assign an_restart  = q.anrs;
   assign col_test    = q.colt;
   assign soft_reset  = q.srst;
   assign wd          = req.wdata;

   // Live status word
   always_comb begin
      stat_v                       = pbm_pkg::STAT_VAL;      // R14
      stat_v[pbm_pkg::STAT_B_ANC]  = an_done;
      stat_v[pbm_pkg::STAT_B_LINK] = link_up;
   end

   // ****************************************
   // Register behaviour
   // ****************************************
   always_comb begin
      n      = q;
      n.anrs = 1'b0;
      n.srst = 1'b0;
      // Strap capture after hard or soft reset
      if (q.ld) begin
         n.ld                   = 1'b0;
         n.bcr[pbm_pkg::B_SPD]  = pkg_large ? strap_speed : 1'b1;    // R7
         n.bcr[pbm_pkg::B_DPX]  = pkg_large ? !strap_duplex : 1'b1;  // R12
         n.bcr[pbm_pkg::B_ANEN] = negotiation_strap_pin;             // R8
      end else if (req.wr) begin
         case (req.addr)
            // Basic control write
            pbm_pkg::REG_CTRL: begin
               if (wd[pbm_pkg::B_RST] && q.bcr[pbm_pkg::B_PD]) begin
                  n.bcr[pbm_pkg::B_PD] = 1'b0;                       // R9
               end else if (wd[pbm_pkg::B_RST]) begin
                  n.bcr  = pbm_pkg::CTRL_RST_VAL;                    // R4
                  n.func = pbm_pkg::FUNC_RST_VAL;
                  n.ld   = 1'b1;                                     // R9
                  n.srst = 1'b1;                                     // R4
               end else begin
                  n.bcr  = wd & pbm_pkg::CTRL_WR_MASK;               // R15
                  n.anrs = wd[pbm_pkg::B_ANRS];                      // R11
               end
            end
            // Function control write
            pbm_pkg::REG_FUNC: begin
               n.func = wd & pbm_pkg::FUNC_WR_MASK;                  // R5
            end
            // Status and unmapped writes ignored
            default: begin
               n.func = q.func;                                      // R15
            end
         endcase
      end
      // Read data capture
      if (req.rd) begin
         case (req.addr)
            pbm_pkg::REG_CTRL:    n.rdata = q.bcr;                   // R13
            pbm_pkg::REG_STAT:    n.rdata = stat_v;                  // R14
            pbm_pkg::REG_MMD_CTL: n.rdata = mmd_ctl;                 // R3
            pbm_pkg::REG_MMD_DAT: n.rdata = mmd_dat;                 // R3
            pbm_pkg::REG_FUNC:    n.rdata = q.func;
            default:              n.rdata = 16'h0000;                // R1
         endcase
      end
      // Effective controls
      n.lpbk = q.bcr[pbm_pkg::B_LPBK] & q.func[pbm_pkg::FUNC_B_LPBK];  // R5
      n.an   = q.bcr[pbm_pkg::B_ANEN];
      if (q.bcr[pbm_pkg::B_ANEN]) begin
         n.spd = an_res_speed;                                         // R8
         n.dpx = an_res_duplex;                                        // R8
      end else begin
         n.spd = q.bcr[pbm_pkg::B_SPD];                                // R6
         n.dpx = q.bcr[pbm_pkg::B_DPX];                                // R12
      end
      n.pd   = q.bcr[pbm_pkg::B_PD];                                   // R9
      n.iso  = q.bcr[pbm_pkg::B_ISO];                                  // R10
      n.colt = q.bcr[pbm_pkg::B_COLT];                                 // R13
   end

   // State register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q    <= '0;
         q.ld <= 1'b1;
      end else if (ce) begin
         q <= n;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst || !ce);

   sequence s_ctl_wr;
      req.wr && req.addr == pbm_pkg::REG_CTRL && !q.ld;
   endsequence

   sequence s_pulse(sig);
      sig ##1 !sig;
   endsequence

   soft_rst_pulse_a: assert property (  // R4
      s_ctl_wr ##0 (wd[pbm_pkg::B_RST] && !q.bcr[pbm_pkg::B_PD])
      |=> s_pulse(soft_reset) ##0 !q.bcr[pbm_pkg::B_RST])
      else $error("soft reset write did not pulse once");

   pd_wake_a: assert property (  // R9
      s_ctl_wr ##0 (wd[pbm_pkg::B_RST] && q.bcr[pbm_pkg::B_PD])
      |=> !soft_reset && !q.ld ##1 !power_down)
      else $error("first reset write in power down misbehaved");

   loop_gate_a: assert property (  // R5
      q.bcr[pbm_pkg::B_LPBK] && !q.func[pbm_pkg::FUNC_B_LPBK] |=> !loopback_on)
      else $error("loopback active without function enable");

   speed_neg_a: assert property (  // R8
      q.bcr[pbm_pkg::B_ANEN]
      |=> speed_100 == $past(an_res_speed) && full_duplex == $past(an_res_duplex))
      else $error("negotiated result not applied");

   speed_man_a: assert property (  // R6
      !q.bcr[pbm_pkg::B_ANEN] |=> speed_100 == $past(q.bcr[pbm_pkg::B_SPD]))
      else $error("manual speed not applied");

   strap_large_a: assert property (  // R12
      q.ld && pkg_large |=> q.bcr[pbm_pkg::B_SPD] == $past(strap_speed)
      && q.bcr[pbm_pkg::B_DPX] == !$past(strap_duplex)
      && q.bcr[pbm_pkg::B_ANEN] == $past(negotiation_strap_pin))
      else $error("strap values not captured");

   strap_small_a: assert property (  // R7
      q.ld && !pkg_large |=> q.bcr[pbm_pkg::B_SPD] && q.bcr[pbm_pkg::B_DPX])
      else $error("small package defaults wrong");

   iso_write_a: assert property (  // R10
      s_ctl_wr ##0 !wd[pbm_pkg::B_RST]
      |=> ##1 isolate == $past(req.wdata[pbm_pkg::B_ISO], 2)
      && col_test == $past(req.wdata[pbm_pkg::B_COLT], 2))
      else $error("isolate or collision test not following write");

   restart_pulse_a: assert property (  // R11
      s_ctl_wr ##0 (wd[pbm_pkg::B_ANRS] && !wd[pbm_pkg::B_RST]) |=> s_pulse(an_restart))
      else $error("restart did not pulse once");

   ctl_read_a: assert property (  // R13
      req.rd && req.addr == pbm_pkg::REG_CTRL
      |=> q.rdata[6:0] == 7'h00 && !q.rdata[pbm_pkg::B_RST] && !q.rdata[pbm_pkg::B_ANRS])
      else $error("control readback shows reserved or self clearing bits");

   stat_read_a: assert property (  // R14
      req.rd && req.addr == pbm_pkg::REG_STAT |=> q.rdata[15:13] == 3'b011)
      else $error("status capability bits wrong");

   vendor_zero_a: assert property (  // R1
      req.rd && req.addr[4] && req.addr != pbm_pkg::REG_FUNC |=> q.rdata == 16'h0000)
      else $error("unused vendor register not zero");

endmodule

// [pbm_host_model.sv]
`timescale 1ns/1ps
// ****************************************
// Management host: frames at falling clk
// ****************************************
module pbm_host_model (
   input  wire logic clk,
   input  wire logic mdio,
   output logic      mdc,
   output logic      host_o,
   output logic      host_oe
);
   // Clock still, line released at rest
   initial begin
      mdc = 1'b0;
      host_o = 1'b1;
      host_oe = 1'b0;
   end
   // Idle bit, 32 frame bits, trailing idle bit; mdc is 8 clk per bit
   task automatic xfer(input logic wr, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
      logic [32:0] f;
      f = {3'b101, wr ? 2'b01 : 2'b10, 5'h01, ra, 2'b10, wd};
      rd = 16'h0000;
      for (int k = 0; k < 34; k++) begin
         // Release for turnaround and data of a read
         host_oe = wr || k < 15 || k > 32;
         host_o = (k < 33) ? f[32-k] : 1'b1;
         mdc = 1'b0;
         repeat (4) @(negedge clk);
         // Device launches each bit at the previous rise; take it before this one
         if (k > 16 && k < 33) rd[32-k] = mdio;
         mdc = 1'b1;
         repeat (4) @(negedge clk);
      end
      host_oe = 1'b0;
      mdc = 1'b0;
   endtask
endmodule

// [phy_basic_mgmt_registers_test.sv]
`timescale 1ns/1ps
module phy_basic_mgmt_registers_test;
   logic clk, nrst, mdc, mdio, host_o, host_oe, mdio_o, mdio_oe;
   logic pkg_large, strap_speed, strap_duplex, negotiation_strap_pin;
   logic an_res_speed, an_res_duplex, an_done, link_up, loopback_on, speed_100;
   logic full_duplex, an_enable, power_down, isolate, an_restart, col_test, soft_reset;
   logic [15:0] rd;
   int errors = 0;
   int comparisons = 0;
   int srst_cnt = 0;
   int anrs_cnt = 0;
   // Pulled-up line
   assign mdio = mdio_oe ? mdio_o : (host_oe ? host_o : 1'b1);
   pbm_mgmt_regs u_pbm_mgmt_regs (.clk(clk), .nrst(nrst), .ce(1'b1), .mdc(mdc),
      .mdio_i(mdio), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .pkg_large(pkg_large),
      .strap_speed(strap_speed), .strap_duplex(strap_duplex),
      .negotiation_strap_pin(negotiation_strap_pin), .an_res_speed(an_res_speed),
      .an_res_duplex(an_res_duplex), .an_done(an_done), .link_up(link_up),
      .loopback_on(loopback_on), .speed_100(speed_100), .full_duplex(full_duplex),
      .an_enable(an_enable), .power_down(power_down), .isolate(isolate),
      .an_restart(an_restart), .col_test(col_test), .soft_reset(soft_reset));
   pbm_host_model u_pbm_host_model (.clk(clk), .mdio(mdio), .mdc(mdc), .host_o(host_o),
      .host_oe(host_oe));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Pulse counters, sampled away from the edge that launches them
   always @(negedge clk) begin
      if (soft_reset === 1'b1) srst_cnt++;
      if (an_restart === 1'b1) anrs_cnt++;
   end
   task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] x;
      u_pbm_host_model.xfer(1'b1, a, d, x);
   endtask
   task automatic rdchk(input string n, input logic [4:0] a, input logic [15:0] e);
      u_pbm_host_model.xfer(1'b0, a, 16'h0000, rd);
      check(n, rd, e);
   endtask
   // Indirect write: address phase then data phase
   task automatic mmd(input logic [4:0] dev, input logic [15:0] ra, input logic [15:0] d);
      wr(5'h0D, {11'h000, dev});
      wr(5'h0E, ra);
      wr(5'h0D, {11'h200, dev});
      wr(5'h0E, d);
   endtask
   task automatic t_reset();
      rdchk("ctrl_reset", 5'h00, 16'h1100);
      check("an_enable", an_enable, 1'b1);
      check("isolate", isolate, 1'b0);
      rdchk("status", 5'h01, pbm_pkg::STAT_VAL | 16'h0024);
   endtask
   task automatic t_fields();
      wr(5'h00, 16'h65FF);
      rdchk("ctrl_rw", 5'h00, 16'h6580);
      check("outs", {speed_100, full_duplex, isolate, col_test, loopback_on}, 5'h1E);
      wr(5'h1C, 16'h0002);
      check("loopback", loopback_on, 1'b1);
      wr(5'h01, 16'h0000);
      rdchk("status_ro", 5'h01, pbm_pkg::STAT_VAL | 16'h0024);
      rdchk("vendor", 5'h10, 16'h0000);
   endtask
   task automatic t_neg();
      wr(5'h00, 16'h1200);
      rdchk("restart_sc", 5'h00, 16'h1000);
      check("restart_cnt", 16'(anrs_cnt), 16'h0001);
      check("override", {speed_100, full_duplex}, 2'b11);
   endtask
   task automatic t_mmd();
      mmd(5'h1C, 16'h00AC, 16'h1234);
      rdchk("sqi", 5'h0E, 16'h1234);
      mmd(5'h07, 16'h003C, 16'hBEEF);
      rdchk("reserved", 5'h0E, 16'h0000);
      mmd(5'h1B, 16'h0000, 16'h00A5);
      rdchk("afe", 5'h0E, 16'h00A5);
   endtask
   task automatic t_pwr();
      wr(5'h00, 16'h0800);
      check("pd_on", power_down, 1'b1);
      wr(5'h00, 16'h8000);
      check("pd_wake", power_down, 1'b0);
      check("pd_no_srst", 16'(srst_cnt), 16'h0000);
      rdchk("pd_ctrl", 5'h00, 16'h0000);
      pkg_large = 1'b0;
      wr(5'h00, 16'h8000);
      check("srst_cnt", 16'(srst_cnt), 16'h0001);
      rdchk("ctrl_small", 5'h00, 16'h3100);
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      nrst = 1'b0;
      {pkg_large, strap_speed, strap_duplex, negotiation_strap_pin} = 4'h9;
      {an_res_speed, an_res_duplex, an_done, link_up} = 4'hF;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      t_fields();
      t_neg();
      t_mmd();
      t_pwr();
      print_verdict();
   end
   // Watchdog, about five times the expected run
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      print_verdict();
   end
endmodule
